// >>> inc/dio_pkg.sv
// Package of constants and carriers for the discrete I/O function logic.
package dio_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int DWELL_TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * DWELL_TICK_MS;
  localparam logic [18:0] TICK_LAST = 19'(TICK_CYCLES - 1);
  localparam int DWELL_MAX_MS = 2550;
  localparam int DWELL_MAX_TICKS = DWELL_MAX_MS / DWELL_TICK_MS;

  // ----------------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_DWELL = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_OUTPUTS = 8'h18;

  // Config and dwell register fields.
  localparam int CF_IN2_LSB = 0;
  localparam int CF_IN3_LSB = 4;
  localparam int CF_IN4_LSB = 8;
  localparam int CF_AUX_LSB = 12;
  localparam int CF_FLUID_RDY = 14;
  localparam int CF_FAULT_RDY = 15;
  localparam int CF_METER = 16;
  localparam int CF_STOP_POS = 17;
  localparam int CF_TRIG_EN = 18;
  localparam int DW_POST_LSB = 8;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [3:0] FN_CLEAR_REF = 4'h0;
  localparam logic [3:0] FN_FLUIDIC_TRIG = 4'h1;
  localparam logic [3:0] FN_MOTION_EN = 4'h2;
  localparam logic [3:0] FN_SAVE_GATE = 4'h3;
  localparam logic [3:0] FN_SAVE_VALUE = 4'h4;
  localparam logic [3:0] FN_SAVE_VALUE_DIR = 4'h5;
  localparam logic [3:0] FN_RECALL_VALUE = 4'h6;
  localparam logic [3:0] FN_RECALL_VALUE_DIR = 4'h7;
  localparam logic [3:0] FN_FULL_GATE = 4'h8;

  localparam logic [1:0] AUX_OFF = 2'h0;
  localparam logic [1:0] AUX_FLUIDIC = 2'h1;
  localparam logic [1:0] AUX_PROD = 2'h2;

  localparam int IRQ_W = 4;
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_CLEAR = 1;
  localparam int IRQ_FLUIDIC = 2;
  localparam int IRQ_MOTION_FAULT = 3;

  // Operating state as reported by the controller core.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_IDLE_REF_REC = 4'h1,
    ST_IDLE_PROD_DIS = 4'h2,
    ST_IDLE_FLUID_DIS = 4'h3,
    ST_NOT_SELECTED = 4'h4,
    ST_MOTION_STOPPED = 4'h5,
    ST_AUTOTRIG_DWELL = 4'h6,
    ST_INITIALIZING = 4'h7,
    ST_FAULTED = 4'h8,
    ST_REFERENCING = 4'h9,
    ST_FLUIDIC_ACTIVE = 4'ha,
    ST_PROD_OPERATING = 4'hb
  } dio_op_state_e;

  // Auxiliary output sequencer.
  typedef enum logic [1:0] {
    AX_IDLE = 2'b00,
    AX_PRE = 2'b01,
    AX_MOVE = 2'b10,
    AX_POST = 2'b11
  } dio_aux_e;

  // Front-panel permission gates.
  typedef struct packed {
    logic recipe_get;
    logic recipe_save;
    logic value_change;
    logic prime_dir;
    logic start_stop;
  } dio_panel_s;

  // Operation requests to the controller core.
  typedef struct packed {
    logic start_op;
    logic meter_run;
    logic meter_stop_pos;
    logic clear_fault;
    logic fluidic_start;
    logic motion_fault;
    logic motion_enable;
    logic move_go;
  } dio_req_s;

endpackage : dio_pkg

// >>> rtl/dio_function_logic.sv
// Discrete input decode, ready output and auxiliary output timing.
// Function
// - Contact closure starts dispense or meter operation.
// - Function 0 clears fault, references if needed.
// - Function 1 starts configured fluidic setup operation.
// - Function 2 enables motion; disabled blocks triggers.
// - Motion disabled while running raises fault.
// - Input four values 3-5 gate save group.
// - Input four values 6-8 gate recall group.
// - Ready conducts in the four idle states.
// - Ready off in listed non-ready states.
// - Aux leads movement by pre-op dwell.
// - Aux holds after movement by post dwell.
// - Fluidic-enable aux drives priming valve.
// - Production-enable aux drives nozzle enable.
// - Dispense starts on edge, completes regardless.
// - Meter runs while applied, per stop mode.
// - Ungated panel functions stay enabled from the first clock after reset.
`timescale 1ns/100ps
module dio_function_logic (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Discrete inputs, high while applied
  input wire logic contact_closure_trigger_i,
  input wire logic config_in2_i,
  input wire logic config_in3_i,
  input wire logic config_in4_i,
  // Controller core status
  input wire dio_pkg::dio_op_state_e op_state_i,
  input wire logic op_running_i,
  input wire logic prod_op_req_i,
  input wire logic prime_active_i,
  input wire logic move_done_i,
  // Requests and gates
  output dio_pkg::dio_req_s req_o,
  output dio_pkg::dio_panel_s panel_o,
  // Outputs, high means conducting
  output logic ready_o,
  output logic aux_o,
  output logic irq_o
);
  import dio_pkg::*;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [18:0] cfg;
    logic [15:0] dwell;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [3:0] in_prev;
    logic [18:0] tick_cnt;
    logic [7:0] dwell_cnt;
    dio_aux_e aux_state;
    dio_req_s req;
    dio_panel_s panel;
    logic ready;
    logic aux;
    logic irq;
  } dio_state_s;

  dio_state_s r;
  dio_state_s next_r;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [3:0] cfg_fn(input logic [18:0] cfg,
                                        input int lsb);
    cfg_fn = cfg[lsb +: 4];
  endfunction : cfg_fn

  function automatic logic ready_of(input dio_op_state_e st,
                                    input logic fluid_rdy,
                                    input logic fault_rdy);
    case (st)
      ST_IDLE, ST_IDLE_REF_REC, ST_IDLE_PROD_DIS,
      ST_IDLE_FLUID_DIS: ready_of = 1'b1;
      ST_FAULTED, ST_REFERENCING: ready_of = fault_rdy;
      ST_FLUIDIC_ACTIVE: ready_of = fluid_rdy;
      default: ready_of = 1'b0;
    endcase
  endfunction : ready_of

  logic [3:0] in_now;
  logic [3:0] in_rise;
  logic apb_wr;
  logic apb_rd;
  logic motion_en;
  logic has_motion_input;
  logic fn_clear;
  logic fn_fluid;
  logic [3:0] in4_fn;
  logic tick;
  logic wr_cfg;
  logic wr_dwell;
  logic wr_clear;
  logic wr_enable;
  logic [31:0] out_word;

  always_comb begin
    in_now = {config_in4_i, config_in3_i, config_in2_i,
              contact_closure_trigger_i};
    // Edges are taken against the previous sample, so a contact that is
    // held through reset shows one rising edge just after release.
    in_rise = in_now & ~r.in_prev;
    apb_wr = psel_i && penable_i && pwrite_i && !r.pready;
    apb_rd = psel_i && penable_i && !pwrite_i && !r.pready;
    // One write strobe per writable register.
    wr_cfg = apb_wr && (paddr_i == ADDR_CONFIG);
    wr_dwell = apb_wr && (paddr_i == ADDR_DWELL);
    wr_clear = apb_wr && (paddr_i == ADDR_IRQ_CLEAR);
    wr_enable = apb_wr && (paddr_i == ADDR_IRQ_ENABLE);
    // Read-only snapshot of ready, aux, the sequencer and the trigger and inputs two and three.
    out_word = {25'h0000000, r.ready, r.aux, r.aux_state, in_now[2:0]};
    in4_fn = cfg_fn(r.cfg, CF_IN4_LSB);
    tick = (r.tick_cnt == TICK_LAST);
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.in_prev = in_now;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    // Free-running 10 ms time base shared by both production dwells.
    if (tick) begin
      next_r.tick_cnt = '0;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 19'h00001;
    end

    // Configurable input two and three decode.
    // Two motion inputs must both be applied; with none configured, motion
    // stays enabled so that a plain trigger wiring still works.
    has_motion_input = 1'b0;
    motion_en = 1'b1;
    fn_clear = 1'b0;
    fn_fluid = 1'b0;
    for (int i = 1; i <= 2; i++) begin
      case (cfg_fn(r.cfg, (i == 1) ? CF_IN2_LSB : CF_IN3_LSB))
        FN_CLEAR_REF: fn_clear |= in_rise[i];
        FN_FLUIDIC_TRIG: fn_fluid |= in_rise[i];
        FN_MOTION_EN: begin
          has_motion_input = 1'b1;
          motion_en &= in_now[i];
        end
        default: ;
      endcase
    end
    // Fourth input may also take functions 0 to 2.
    case (in4_fn)
      FN_CLEAR_REF: fn_clear |= in_rise[3];
      FN_FLUIDIC_TRIG: fn_fluid |= in_rise[3];
      FN_MOTION_EN: begin
        has_motion_input = 1'b1;
        motion_en &= in_now[3];
      end
      default: ;
    endcase

    next_r.req.motion_enable = motion_en;
    next_r.req.clear_fault = fn_clear;
    next_r.req.fluidic_start = fn_fluid && motion_en;
    // A falling motion input mid-operation is a one-shot fault.
    next_r.req.motion_fault = has_motion_input && !motion_en &&
                              r.req.motion_enable && op_running_i;
    // Dispense fires once per applied edge; the core finishes the dose on
    // its own, so removal of the contact is not forwarded.
    next_r.req.start_op = r.cfg[CF_TRIG_EN] && !r.cfg[CF_METER] &&
                          in_rise[0] && motion_en;
    next_r.req.meter_run = r.cfg[CF_TRIG_EN] && r.cfg[CF_METER] &&
                           in_now[0] && motion_en;
    // The stop mode travels to the core as a level; it acts on release.
    next_r.req.meter_stop_pos = r.cfg[CF_STOP_POS];

    // Front-panel gates; unlisted functions stay open.
    next_r.panel = '1;
    case (in4_fn)
      FN_SAVE_GATE: next_r.panel.recipe_save = in_now[3];
      FN_SAVE_VALUE: begin
        next_r.panel.recipe_save = in_now[3];
        next_r.panel.value_change = in_now[3];
      end
      FN_SAVE_VALUE_DIR: begin
        next_r.panel.recipe_save = in_now[3];
        next_r.panel.value_change = in_now[3];
        next_r.panel.prime_dir = in_now[3];
      end
      FN_RECALL_VALUE, FN_RECALL_VALUE_DIR, FN_FULL_GATE: begin
        next_r.panel.recipe_get = in_now[3];
        next_r.panel.recipe_save = in_now[3];
        next_r.panel.value_change = in_now[3];
        if (in4_fn != FN_RECALL_VALUE) begin
          next_r.panel.prime_dir = in_now[3];
        end
        if (in4_fn == FN_FULL_GATE) begin
          next_r.panel.start_stop = in_now[3];
        end
      end
      default: ;
    endcase

    // Registered so the pin never glitches while the core state moves.
    next_r.ready = ready_of(op_state_i, r.cfg[CF_FLUID_RDY],
                            r.cfg[CF_FAULT_RDY]);

    // Production-enable aux: lead, move, hold. The core waits for move_go.
    next_r.req.move_go = 1'b0;
    case (r.aux_state)
      AX_IDLE: begin
        if (prod_op_req_i) begin
          next_r.dwell_cnt = r.dwell[DW_POST_LSB-1:0];
          next_r.aux_state = AX_PRE;
        end
      end
      AX_PRE: begin
        // A zero dwell releases the core on the very next cycle.
        if (r.dwell_cnt == 8'h00) begin
          next_r.req.move_go = 1'b1;
          next_r.aux_state = AX_MOVE;
        end else if (tick) begin
          next_r.dwell_cnt = r.dwell_cnt - 8'h01;
        end
      end
      AX_MOVE: begin
        if (move_done_i) begin
          next_r.dwell_cnt = r.dwell[DW_POST_LSB +: 8];
          next_r.aux_state = AX_POST;
        end
      end
      AX_POST: begin
        // The output drops two cycles after the count runs out.
        if (r.dwell_cnt == 8'h00) begin
          next_r.aux_state = AX_IDLE;
        end else if (tick) begin
          next_r.dwell_cnt = r.dwell_cnt - 8'h01;
        end
      end
      default: next_r.aux_state = AX_IDLE;
    endcase

    case (r.cfg[CF_AUX_LSB +: 2])
      AUX_FLUIDIC: next_r.aux = prime_active_i;
      AUX_PROD: next_r.aux = (r.aux_state != AX_IDLE);
      default: next_r.aux = 1'b0;
    endcase

    // ----------------------------------------------------------------------
    // Interrupts: a new event wins over a simultaneous clear.
    // ----------------------------------------------------------------------
    if (wr_clear) begin
      next_r.irq_status = r.irq_status & ~pwdata_i[IRQ_W-1:0];
    end
    next_r.irq_status[IRQ_TRIG] |= next_r.req.start_op;
    next_r.irq_status[IRQ_CLEAR] |= fn_clear;
    next_r.irq_status[IRQ_FLUIDIC] |= next_r.req.fluidic_start;
    next_r.irq_status[IRQ_MOTION_FAULT] |= next_r.req.motion_fault;
    next_r.irq = |(next_r.irq_status & r.irq_enable);

    // ----------------------------------------------------------------------
    // APB: answers one cycle into the access phase.
    // ----------------------------------------------------------------------
    // A wrong access answers with an error at once, except a write to the
    // state register, which is dropped with no error like a write that landed.
    if (apb_wr || apb_rd) begin
      next_r.pready = 1'b1;
      next_r.prdata = '0;
      case (paddr_i)
        ADDR_CONFIG: begin
          if (wr_cfg) begin
            next_r.cfg = pwdata_i[18:0];
          end
          next_r.prdata = {13'h0000, r.cfg};
        end
        ADDR_STATE: begin
          next_r.prdata = {28'h0000000, op_state_i};
        end
        ADDR_DWELL: begin
          if (wr_dwell) begin
            next_r.dwell = pwdata_i[15:0];
          end
          next_r.prdata = {16'h0000, r.dwell};
        end
        ADDR_IRQ_STATUS: begin
          next_r.pslverr = apb_wr;
          next_r.prdata = {28'h0000000, r.irq_status};
        end
        ADDR_IRQ_CLEAR: begin
          // Write-only: a read is refused.
          next_r.pslverr = apb_rd;
        end
        ADDR_IRQ_ENABLE: begin
          if (wr_enable) begin
            next_r.irq_enable = pwdata_i[IRQ_W-1:0];
          end
          next_r.prdata = {28'h0000000, r.irq_enable};
        end
        ADDR_OUTPUTS: begin
          next_r.pslverr = apb_wr;
          next_r.prdata = out_word;
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end
  end

  // Every output is a field of this one register, straight from a flop.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata_o = r.prdata;
  assign pready_o = r.pready;
  assign pslverr_o = r.pslverr;
  assign req_o = r.req;
  assign panel_o = r.panel;
  assign ready_o = r.ready;
  assign aux_o = r.aux;
  assign irq_o = r.irq;

endmodule : dio_function_logic

// >>> tb/dio_function_logic_chk.sv
// Port checker for the discrete I/O function logic.
`timescale 1ns/100ps
module dio_function_logic_chk
  import dio_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Watched ports
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic contact_closure_trigger_i,
  input wire logic config_in4_i,
  input wire dio_pkg::dio_op_state_e op_state_i,
  input wire logic op_running_i,
  input wire dio_pkg::dio_req_s req_o,
  input wire dio_pkg::dio_panel_s panel_o,
  input wire logic ready_o,
  input wire logic aux_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_rdy_on;
    op_state_i inside {ST_IDLE, ST_IDLE_REF_REC, ST_IDLE_PROD_DIS,
      ST_IDLE_FLUID_DIS} |=> ready_o;
  endproperty
  a_rdy_on: assert property (p_rdy_on)
    else $error("ready off in an idle state");
  property p_rdy_off;
    op_state_i inside {ST_NOT_SELECTED, ST_MOTION_STOPPED, ST_AUTOTRIG_DWELL,
      ST_INITIALIZING, ST_PROD_OPERATING} |=> !ready_o;
  endproperty
  a_rdy_off: assert property (p_rdy_off)
    else $error("ready on in a busy state");
  property p_start_src;
    req_o.start_op |-> $past(contact_closure_trigger_i);
  endproperty
  a_start_src: assert property (p_start_src)
    else $error("start without trigger");
  property p_meter_src;
    req_o.meter_run |-> $past(contact_closure_trigger_i);
  endproperty
  a_meter_src: assert property (p_meter_src)
    else $error("meter runs without trigger");
  property p_motion_block;
    !req_o.motion_enable && !$past(req_o.motion_enable)
      |-> !req_o.start_op && !req_o.fluidic_start;
  endproperty
  a_motion_block: assert property (p_motion_block)
    else $error("operation started while motion disabled");
  property p_motion_fault;
    $fell(req_o.motion_enable) && $past(op_running_i)
      |-> ##[0:2] req_o.motion_fault;
  endproperty
  a_motion_fault: assert property (p_motion_fault)
    else $error("no fault on motion loss in operation");
  property p_panel_ss;
    $past(reset_n_i) && !panel_o.start_stop |-> !$past(config_in4_i);
  endproperty
  a_panel_ss: assert property (p_panel_ss)
    else $error("start and stop gated with input applied");
  property p_aux_move;
    req_o.move_go |=> aux_o;
  endproperty
  a_aux_move: assert property (p_aux_move)
    else $error("aux off during movement");
  property p_apb_ans;
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o;
  endproperty
  a_apb_ans: assert property (p_apb_ans)
    else $error("bus answer missing or too long");
endmodule : dio_function_logic_chk

// >>> tb/dio_plc_model.sv
// Model of the external PLC that drives the discrete inputs.
`timescale 1ns/100ps
module dio_plc_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Requested pattern: trigger, input two, three, four
  input wire logic [3:0] cmd_i,
  // Contacts, high while applied
  output logic trig_o,
  output logic in2_o,
  output logic in3_o,
  output logic in4_o
);
  // Dry contacts only: the model never sources its own power.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {trig_o, in2_o, in3_o, in4_o} <= 4'h0;
    end else begin
      {trig_o, in2_o, in3_o, in4_o} <= cmd_i;
    end
  end
endmodule : dio_plc_model

// >>> tb/dio_function_logic_bench.sv
// Self-checking bench for the discrete I/O function logic.
`timescale 1ns/100ps
module dio_function_logic_bench;
  import dio_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic contact_closure_trigger_i, config_in2_i, config_in3_i, config_in4_i;
  dio_op_state_e op_state_i;
  logic op_running_i, prod_op_req_i, prime_active_i, move_done_i;
  dio_req_s req_o;
  dio_panel_s panel_o;
  logic ready_o, aux_o, irq_o;
  logic [3:0] cmd;
  int mismatches = 0, n_checks = 0, cycles = 0, seed = 54623, st, f, k;

  dio_function_logic u_dio_function_logic (.sys_clk_i, .reset_n_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .contact_closure_trigger_i, .config_in2_i,
    .config_in3_i, .config_in4_i, .op_state_i, .op_running_i,
    .prod_op_req_i, .prime_active_i, .move_done_i, .req_o, .panel_o,
    .ready_o, .aux_o, .irq_o);
  dio_plc_model u_dio_plc_model (.sys_clk_i, .reset_n_i, .cmd_i(cmd),
    .trig_o(contact_closure_trigger_i), .in2_o(config_in2_i),
    .in3_o(config_in3_i), .in4_o(config_in4_i));

  initial forever #12.5 sys_clk_i = ~sys_clk_i;

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // A hung handshake would otherwise stall the run forever.
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic err);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    chk(pslverr_o, err);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // The model adds a cycle; the result is settled two edges later.
  task automatic pins(logic [3:0] v);
    @(posedge sys_clk_i);
    cmd <= v;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : pins

  function automatic logic rdy_exp(int s, logic fl, logic ft);
    if (s < 4)
      return 1'b1;
    if (s == 8 || s == 9)
      return ft;
    return (s == 10) ? fl : 1'b0;
  endfunction : rdy_exp

  function automatic logic [4:0] pan_exp(int fn, logic on);
    logic [4:0] m;
    case (fn)
      3: m = 5'h08;
      4: m = 5'h0c;
      5: m = 5'h0e;
      6: m = 5'h1c;
      7: m = 5'h1e;
      default: m = 5'h1f;
    endcase
    return on ? 5'h1f : ~m;
  endfunction : pan_exp

  initial begin
    {psel_i, penable_i, pwrite_i, op_running_i, prod_op_req_i} = 5'h0;
    {prime_active_i, move_done_i, paddr_i, pwdata_i, cmd} = '0;
    op_state_i = ST_IDLE;
    repeat (4) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, ADDR_CONFIG, 32'h0, 1'b0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h1c, 32'h0, 1'b1);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h0, 1'b1);
    apb(1'b0, ADDR_IRQ_CLEAR, 32'h0, 1'b1);
    for (k = 0; k < 60; k++) begin
      st = k < 48 ? k % 12 : {$random(seed)} % 12;
      f = k < 48 ? k / 12 : {$random(seed)} % 4;
      apb(1'b1, ADDR_CONFIG, f << 14, 1'b0);
      @(posedge sys_clk_i);
      op_state_i <= dio_op_state_e'(st);
      repeat (2) @(posedge sys_clk_i);
      #1 chk(ready_o, rdy_exp(st, f[0], f[1]));
      apb(1'b0, ADDR_STATE, 32'h0, 1'b0);
      chk(rd, st);
    end
    op_state_i <= ST_IDLE;
    apb(1'b1, ADDR_CONFIG, 32'h4_0000, 1'b0);
    pins(4'h8);
    chk(req_o.start_op, 1'b1);
    pins(4'h8);
    chk({req_o.start_op, irq_o}, 2'b00);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0, 1'b0);
    chk(rd, 32'h1);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h1, 1'b0);
    pins(4'h0);
    chk(irq_o, 1'b1);
    apb(1'b1, ADDR_IRQ_CLEAR, 32'h1, 1'b0);
    pins(4'h0);
    chk(irq_o, 1'b0);
    apb(1'b1, ADDR_CONFIG, 32'h7_0000, 1'b0);
    pins(4'h8);
    chk({req_o.meter_run, req_o.meter_stop_pos}, 2'b11);
    pins(4'h0);
    chk(req_o.meter_run, 1'b0);
    apb(1'b1, ADDR_CONFIG, 32'h10, 1'b0);
    pins(4'h6);
    chk({req_o.clear_fault, req_o.fluidic_start}, 2'b11);
    apb(1'b1, ADDR_CONFIG, 32'h4_0002, 1'b0);
    pins(4'h8);
    chk({req_o.motion_enable, req_o.start_op}, 2'b00);
    pins(4'h4);
    chk(req_o.motion_enable, 1'b1);
    @(posedge sys_clk_i) op_running_i <= 1'b1;
    pins(4'h0);
    chk(req_o.motion_fault, 1'b1);
    @(posedge sys_clk_i) op_running_i <= 1'b0;
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0, 1'b0);
    chk(rd, 32'he);
    for (f = 3; f < 9; f++) begin
      apb(1'b1, ADDR_CONFIG, f << 8, 1'b0);
      for (k = 0; k < 2; k++) begin
        pins(k[3:0]);
        chk(panel_o, pan_exp(f, k[0]));
      end
    end
    apb(1'b1, ADDR_CONFIG, 32'h1000, 1'b0);
    for (k = 1; k >= 0; k--) begin
      @(posedge sys_clk_i);
      prime_active_i <= k[0];
      repeat (3) @(posedge sys_clk_i);
      #1 chk(aux_o, k[0]);
    end
    apb(1'b1, ADDR_CONFIG, 32'h2000, 1'b0);
    apb(1'b1, ADDR_DWELL, 32'h0, 1'b0);
    @(posedge sys_clk_i);
    prod_op_req_i <= 1'b1;
    @(posedge sys_clk_i);
    prod_op_req_i <= 1'b0;
    @(posedge sys_clk_i);
    #1 chk(req_o.move_go, 1'b1);
    repeat (19) @(posedge sys_clk_i);
    #1 chk(aux_o, 1'b1);
    @(posedge sys_clk_i);
    move_done_i <= 1'b1;
    @(posedge sys_clk_i);
    move_done_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1 chk(aux_o, 1'b0);
    results();
  end
endmodule : dio_function_logic_bench

bind dio_function_logic dio_function_logic_chk u_dio_function_logic_chk (
  .sys_clk_i, .reset_n_i, .psel_i, .penable_i, .pready_o,
  .contact_closure_trigger_i, .config_in4_i, .op_state_i, .op_running_i,
  .req_o, .panel_o, .ready_o, .aux_o);
